// ==== core/dsm_pkg.sv ====
package dsm_pkg;

  // register addresses: odd address is the upper byte of the word
  localparam logic [6:0] ADDR_THR1       = 7'h26;
  localparam logic [6:0] ADDR_THR2       = 7'h28;
  localparam logic [6:0] ADDR_CNT1       = 7'h2A;
  localparam logic [6:0] ADDR_CNT2       = 7'h2C;
  localparam logic [6:0] ADDR_ALARM_CTRL = 7'h2E;
  localparam logic [6:0] ADDR_MISC_CTRL  = 7'h34;
  localparam logic [6:0] ADDR_STATUS     = 7'h3C;

  // misc_control fields
  localparam int MISC_MEMTEST  = 11;
  localparam int MISC_SELFTEST = 10;
  localparam int MISC_DR_EN    = 2;
  localparam int MISC_DR_POL   = 1;
  localparam int MISC_DR_LINE  = 0;

  // alarm_control fields
  localparam int CTRL_SRC1_LSB = 8;
  localparam int CTRL_RATE1    = 6;
  localparam int CTRL_FILT     = 4;
  localparam int CTRL_OUT_EN   = 2;
  localparam int CTRL_OUT_POL  = 1;
  localparam int CTRL_OUT_LINE = 0;
  localparam int SRC_WIDTH     = 4;

  // alarm threshold fields
  localparam int MAG_POL       = 15;
  localparam int DATA_BITS     = 14;

  // diag_status_flags fields
  localparam int ST_SUP_LOW    = 0;
  localparam int ST_SUP_HIGH   = 1;
  localparam int ST_FLASH_UPD  = 2;
  localparam int ST_SPI_FAIL   = 3;
  localparam int ST_OVERRANGE  = 4;
  localparam int ST_DIAG_ERR   = 5;
  localparam int ST_FLASH_SUM  = 6;
  localparam int ST_ALARM1     = 8;
  localparam int ST_SELFTEST   = 10;

  // writable bits and values after reset
  localparam logic [15:0] MISC_MASK  = 16'h0FC7;
  localparam logic [15:0] CTRL_MASK  = 16'hFFD7;
  localparam logic [15:0] MAG_MASK   = 16'hBFFF;
  localparam logic [15:0] SMPL_MASK  = 16'h00FF;
  localparam logic [15:0] MISC_RST   = 16'h0006;
  localparam logic [15:0] ALARM_RST  = 16'h0000;
  localparam logic [15:0] STATUS_RST = 16'h0000;

  localparam int        FRAME_BITS = 16;
  localparam int        NUM_SRC    = 11;
  localparam int        HIST_DEPTH = 256;
  localparam logic [7:0] CNT_ONE   = 8'h01;

  typedef enum logic [3:0] {
    SRC_OFF    = 4'h0,
    SRC_SUPPLY = 4'h1,
    SRC_GYRO_X = 4'h2,
    SRC_GYRO_Y = 4'h3,
    SRC_GYRO_Z = 4'h4,
    SRC_ACCL_X = 4'h5,
    SRC_ACCL_Y = 4'h6,
    SRC_ACCL_Z = 4'h7,
    SRC_TEMP   = 4'h8,
    SRC_INCL_X = 4'h9,
    SRC_INCL_Y = 4'hA,
    SRC_AUX    = 4'hB
  } dsm_src_e;

  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [7:0] data;
  } dsm_frame_s;

endpackage

// ==== core/dsm_monitor.sv ====
`timescale 1ns/100ps
module dsm_monitor (
  input  wire logic                                 clk,           // core
  input  wire logic                                 reset_n,       // async
  input  wire logic                                 sclk,          // spi clk
  input  wire logic                                 cs_n,          // frame
  input  wire logic                                 mosi,          // in
  output logic                                      miso,          // out
  input  wire logic                                 sampleTick,    // pulse
  input  wire logic [dsm_pkg::NUM_SRC-1:0][13:0]    srcRaw,        // data
  input  wire logic [dsm_pkg::NUM_SRC-1:0][13:0]    srcFilt,       // data
  input  wire logic                                 dataReady,     // level
  input  wire logic                                 selfTestDone,  // pulse
  input  wire logic [5:0]                           selfTestFail,  // result
  input  wire logic                                 selfTestErr,   // result
  input  wire logic                                 flashChkDone,  // pulse
  input  wire logic                                 flashChkBad,   // result
  input  wire logic                                 overrange,     // level
  input  wire logic                                 spiFault,      // level
  input  wire logic                                 flashUpdFail,  // level
  input  wire logic                                 supplyHighPin, // async
  input  wire logic                                 supplyLowPin,  // async
  output logic                                      selfTestGo,    // level
  output logic                                      flashChkGo,    // level
  output logic [1:0]                                ioLineOut,     // value
  output logic [1:0]                                ioLineOe       // drive
);

  logic        rstS1, rstN;
  logic [3:0]  bitCnt_r;
  logic [14:0] rxShift_r;
  logic [15:0] frameWord_r;
  logic        frameTgl_r;
  logic [15:0] txShift_r;
  logic        tglS1, tglS2, tglS3;
  logic        supHiS1, supHiS2, supLoS1, supLoS2;
  logic [15:0] rdData_r;
  logic [15:0] miscR, ctrlR, statusR;
  logic [15:0] magR [2];
  logic [15:0] smplR [2];
  logic [5:0]  stFailR;
  logic        stErrR, flashBadR;
  logic [1:0]  alarmNxt, alarmAct_r;
  logic [15:0] conds;
  logic        frameEv, diagRead, wrEv;
  logic [1:0]  drOwn, alOwn;
  logic        drLevel, alLevel;
  dsm_pkg::dsm_frame_s frame;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstS1 <= 1'b0;
      rstN  <= 1'b0;
    end else begin
      rstS1 <= 1'b1;
      rstN  <= rstS1;
    end
  end

  // link side: the frame's own chip select ends every frame
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bitCnt_r  <= 4'h0;
      rxShift_r <= 15'h0000;
    end else begin
      bitCnt_r  <= bitCnt_r + 4'h1;
      rxShift_r <= {rxShift_r[13:0], mosi};
    end
  end

  // word and toggle survive chip select so the core can fetch them
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      frameWord_r <= 16'h0000;
      frameTgl_r  <= 1'b0;
    end else if (!cs_n && bitCnt_r == 4'(dsm_pkg::FRAME_BITS - 1)) begin
      frameWord_r <= {rxShift_r, mosi};
      frameTgl_r  <= ~frameTgl_r;
    end
  end

  // rdData_r only changes a few core cycles after a frame, so it is
  // stable by the next frame's first falling edge
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      txShift_r <= 16'h0000;
    end else if (bitCnt_r == 4'h0) begin
      txShift_r <= rdData_r;
    end else begin
      txShift_r <= {txShift_r[14:0], 1'b0};
    end
  end
  assign miso = txShift_r[15];

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      tglS1   <= 1'b0;
      tglS2   <= 1'b0;
      tglS3   <= 1'b0;
      supHiS1 <= 1'b0;
      supHiS2 <= 1'b0;
      supLoS1 <= 1'b0;
      supLoS2 <= 1'b0;
    end else begin
      tglS1   <= frameTgl_r;
      tglS2   <= tglS1;
      tglS3   <= tglS2;
      supHiS1 <= supplyHighPin;
      supHiS2 <= supHiS1;
      supLoS1 <= supplyLowPin;
      supLoS2 <= supLoS1;
    end
  end

  assign frameEv  = tglS2 ^ tglS3;
  assign frame    = dsm_pkg::dsm_frame_s'(frameWord_r);
  assign wrEv     = frameEv && frame.wr;
  assign diagRead = frameEv && !frame.wr &&
                    frame.addr[6:1] == dsm_pkg::ADDR_STATUS[6:1];

  function automatic logic [15:0] byteWr(input logic [15:0] old,
                                         input logic        hi,
                                         input logic [7:0]  d,
                                         input logic [15:0] mask);
    byteWr = (hi ? {d, old[7:0]} : {old[15:8], d}) & mask;
  endfunction

  function automatic logic hits(input logic [6:0] a, input logic [6:0] r);
    hits = a[6:1] == r[6:1];
  endfunction

  // read answer, shifted out during the next frame
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rdData_r <= 16'h0000;
    end else if (frameEv && !frame.wr) begin
      unique case (1'b1)
        hits(frame.addr, dsm_pkg::ADDR_STATUS):     rdData_r <= statusR;
        hits(frame.addr, dsm_pkg::ADDR_MISC_CTRL):  rdData_r <= miscR;
        hits(frame.addr, dsm_pkg::ADDR_ALARM_CTRL): rdData_r <= ctrlR;
        hits(frame.addr, dsm_pkg::ADDR_THR1):       rdData_r <= magR[0];
        hits(frame.addr, dsm_pkg::ADDR_THR2):       rdData_r <= magR[1];
        hits(frame.addr, dsm_pkg::ADDR_CNT1):       rdData_r <= smplR[0];
        hits(frame.addr, dsm_pkg::ADDR_CNT2):       rdData_r <= smplR[1];
        default:                                    rdData_r <= 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ctrlR    <= dsm_pkg::ALARM_RST;
      magR[0]  <= dsm_pkg::ALARM_RST;
      magR[1]  <= dsm_pkg::ALARM_RST;
      smplR[0] <= dsm_pkg::ALARM_RST;
      smplR[1] <= dsm_pkg::ALARM_RST;
    end else if (wrEv) begin
      if (hits(frame.addr, dsm_pkg::ADDR_ALARM_CTRL))
        ctrlR <= byteWr(ctrlR, frame.addr[0], frame.data,
                        dsm_pkg::CTRL_MASK);
      if (hits(frame.addr, dsm_pkg::ADDR_THR1))
        magR[0] <= byteWr(magR[0], frame.addr[0], frame.data,
                          dsm_pkg::MAG_MASK);
      if (hits(frame.addr, dsm_pkg::ADDR_THR2))
        magR[1] <= byteWr(magR[1], frame.addr[0], frame.data,
                          dsm_pkg::MAG_MASK);
      if (hits(frame.addr, dsm_pkg::ADDR_CNT1))
        smplR[0] <= byteWr(smplR[0], frame.addr[0], frame.data,
                           dsm_pkg::SMPL_MASK);
      if (hits(frame.addr, dsm_pkg::ADDR_CNT2))
        smplR[1] <= byteWr(smplR[1], frame.addr[0], frame.data,
                           dsm_pkg::SMPL_MASK);
    end
  end

  // test bits clear on completion; completion beats a same-cycle write
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      miscR <= dsm_pkg::MISC_RST;
    end else begin
      logic [15:0] m;
      m = miscR;
      if (wrEv && hits(frame.addr, dsm_pkg::ADDR_MISC_CTRL))
        m = byteWr(miscR, frame.addr[0], frame.data, dsm_pkg::MISC_MASK);
      if (selfTestDone)
        m[dsm_pkg::MISC_SELFTEST] = 1'b0;
      if (flashChkDone)
        m[dsm_pkg::MISC_MEMTEST] = 1'b0;
      miscR <= m;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      selfTestGo <= 1'b0;
      flashChkGo <= 1'b0;
    end else begin
      selfTestGo <= miscR[dsm_pkg::MISC_SELFTEST] && !selfTestDone;
      flashChkGo <= miscR[dsm_pkg::MISC_MEMTEST] && !flashChkDone;
    end
  end

  // test verdicts stay as conditions until the next run replaces them
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stFailR   <= 6'h00;
      stErrR    <= 1'b0;
      flashBadR <= 1'b0;
    end else begin
      if (selfTestDone) begin
        stFailR <= selfTestFail;
        stErrR  <= selfTestErr;
      end
      if (flashChkDone)
        flashBadR <= flashChkBad;
    end
  end

  always_comb begin
    conds = 16'h0000;
    conds[15:dsm_pkg::ST_SELFTEST]        = stFailR;
    conds[dsm_pkg::ST_ALARM1 +: 2]        = alarmNxt;
    conds[dsm_pkg::ST_FLASH_SUM]          = flashBadR;
    conds[dsm_pkg::ST_DIAG_ERR]           = stErrR;
    conds[dsm_pkg::ST_OVERRANGE]          = overrange;
    conds[dsm_pkg::ST_SPI_FAIL]           = spiFault;
    conds[dsm_pkg::ST_FLASH_UPD]          = flashUpdFail;
    conds[dsm_pkg::ST_SUP_HIGH]           = supHiS2;
    conds[dsm_pkg::ST_SUP_LOW]            = supLoS2;
  end

  // a sample in the read cycle re-sets its flag: set wins over clear
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      statusR <= dsm_pkg::STATUS_RST;
    end else begin
      if (sampleTick) begin
        statusR[15:2] <= (diagRead ? 14'h0000 : statusR[15:2]) |
                         conds[15:2];
        statusR[1:0]  <= conds[1:0];
      end else if (diagRead) begin
        statusR[15:2] <= 14'h0000;
      end
    end
  end

  generate
    for (genvar i = 0; i < 2; i++) begin : g_alarm
      logic [3:0]  sel;
      logic        rateMode, useFilt, selOk, fillOk, hit;
      logic [3:0]  idx;
      logic [7:0]  nSmp, wp_r, fill_r, rdPtr;
      logic [13:0] val, old;
      logic signed [14:0] cmpV, thrV;
      logic [13:0] hist [dsm_pkg::HIST_DEPTH];

      assign sel   = ctrlR[dsm_pkg::CTRL_SRC1_LSB + 4*i +: 4];
      assign rateMode = ctrlR[dsm_pkg::CTRL_RATE1 + i];
      assign selOk = sel != dsm_pkg::SRC_OFF && sel <= dsm_pkg::SRC_AUX;
      assign idx   = selOk ? sel - 4'h1 : 4'h0;
      assign useFilt = ctrlR[dsm_pkg::CTRL_FILT] ||
                       sel == dsm_pkg::SRC_INCL_X ||
                       sel == dsm_pkg::SRC_INCL_Y;
      assign val   = useFilt ? srcFilt[idx] : srcRaw[idx];
      // zero and one both mean a single sample
      assign nSmp  = (smplR[i][7:0] <= dsm_pkg::CNT_ONE) ?
                     dsm_pkg::CNT_ONE : smplR[i][7:0];
      // one history entry per sample tick, so the span is nSmp periods
      assign rdPtr = wp_r - nSmp;
      assign old   = hist[rdPtr];
      assign fillOk = !rateMode || fill_r >= nSmp;
      assign thrV  = {magR[i][13], magR[i][13:0]};
      assign cmpV  = rateMode ?
                     $signed({val[13], val}) - $signed({old[13], old}) :
                     $signed({val[13], val});
      assign hit   = magR[i][dsm_pkg::MAG_POL] ? (cmpV > thrV)
                                               : (cmpV < thrV);
      assign alarmNxt[i] = selOk && fillOk && hit;

      // history holds data only; no reset needed
      always_ff @(posedge clk) begin
        if (sampleTick)
          hist[wp_r] <= val;
      end

      always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
          wp_r   <= 8'h00;
          fill_r <= 8'h00;
        end else if (sampleTick) begin
          wp_r <= wp_r + 8'h01;
          if (fill_r != 8'hFF)
            fill_r <= fill_r + 8'h01;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN)
      alarmAct_r <= 2'b00;
    else if (sampleTick)
      alarmAct_r <= alarmNxt;
  end

  assign drOwn[0] = miscR[dsm_pkg::MISC_DR_EN] && !miscR[dsm_pkg::MISC_DR_LINE];
  assign drOwn[1] = miscR[dsm_pkg::MISC_DR_EN] && miscR[dsm_pkg::MISC_DR_LINE];
  assign alOwn[0] = ctrlR[dsm_pkg::CTRL_OUT_EN] &&
                    !ctrlR[dsm_pkg::CTRL_OUT_LINE] && !drOwn[0];
  assign alOwn[1] = ctrlR[dsm_pkg::CTRL_OUT_EN] &&
                    ctrlR[dsm_pkg::CTRL_OUT_LINE] && !drOwn[1];
  assign drLevel  = miscR[dsm_pkg::MISC_DR_POL] ? dataReady : !dataReady;
  assign alLevel  = ctrlR[dsm_pkg::CTRL_OUT_POL] ? |alarmAct_r
                                                 : !(|alarmAct_r);

  // unclaimed lines are released; plain GPIO data lives elsewhere
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ioLineOut <= 2'b00;
      ioLineOe  <= 2'b00;
    end else begin
      for (int k = 0; k < 2; k++) begin
        ioLineOut[k] <= drOwn[k] ? drLevel :
                        alOwn[k] ? alLevel : 1'b0;
        ioLineOe[k]  <= drOwn[k] | alOwn[k];
      end
    end
  end

  read_clears_a: assert property (@(posedge clk) disable iff (!rstN)
    diagRead && !sampleTick |=> statusR[15:2] == 14'h0000)
    else $error("status flags not cleared by read");

  supply_kept_a: assert property (@(posedge clk) disable iff (!rstN)
    diagRead && !sampleTick |=> $stable(statusR[1:0]))
    else $error("supply flags changed by read");

  supply_follow_a: assert property (@(posedge clk) disable iff (!rstN)
    sampleTick |=> statusR[1] == $past(supHiS2) &&
                   statusR[0] == $past(supLoS2))
    else $error("supply flags do not follow supply");

  error_reset_a: assert property (@(posedge clk) disable iff (!rstN)
    sampleTick && spiFault |=> statusR[3])
    else $error("persisting serial fault not flagged again");

  alarm_status_a: assert property (@(posedge clk) disable iff (!rstN)
    sampleTick |=> statusR[9:8] == (alarmAct_r |
      ($past(diagRead) ? 2'b00 : $past(statusR[9:8]))))
    else $error("alarm status bits differ from alarm state");

  flash_result_a: assert property (@(posedge clk) disable iff (!rstN)
    flashChkDone |=> !miscR[11] && flashBadR == $past(flashChkBad))
    else $error("memory test completion mishandled");

  alarm_line_a: assert property (@(posedge clk) disable iff (!rstN)
    alOwn[0] |=> ioLineOe[0] &&
                 ioLineOut[0] == $past(alLevel))
    else $error("alarm line level wrong");

  line_priority_a: assert property (@(posedge clk) disable iff (!rstN)
    drOwn[0] && ctrlR[2] && !ctrlR[0] |=>
      ioLineOut[0] == $past(drLevel))
    else $error("alarm took a line held by data ready");

  static_cmp_a: assert property (@(posedge clk) disable iff (!rstN)
    sampleTick && !g_alarm[0].rateMode && g_alarm[0].selOk |=>
      alarmAct_r[0] == ($past(magR[0][15]) ?
        $past(g_alarm[0].cmpV) > $past(g_alarm[0].thrV) :
        $past(g_alarm[0].cmpV) < $past(g_alarm[0].thrV)))
    else $error("static comparison wrong");

endmodule

// ==== sim/dsm_host.sv ====
`timescale 1ns/100ps
module dsm_host (
  output logic      sclk, // spi clock, idle high
  output logic      cs_n, // frame select
  output logic      mosi, // data to device
  input  wire logic miso  // data from device
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // one 16-bit frame, mode 3; the clock stands still between frames
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    cs_n = 1'b0;
    #6;
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'b0;
      mosi = tx[i];
      #6;
      sclk = 1'b1;
      rx[i] = miso;
      #6;
    end
    #6;
    cs_n = 1'b1;
    // released line must not keep showing the last bit
    mosi = ~mosi;
    // gap well above the device's frame settling time
    #100;
  endtask
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  logic clk, reset_n, sclk, cs_n, mosi, miso, sampleTick, dataReady;
  logic selfTestDone, selfTestErr, flashChkDone, flashChkBad;
  logic overrange, spiFault, flashUpdFail, supplyHighPin, supplyLowPin;
  logic selfTestGo, flashChkGo;
  logic [5:0]                        selfTestFail;
  logic [1:0]                        ioLineOut;
  logic [1:0]                        ioLineOe;
  logic [dsm_pkg::NUM_SRC-1:0][13:0] srcRaw;
  logic [dsm_pkg::NUM_SRC-1:0][13:0] srcFilt;
  logic [15:0]                       seed;
  int                                bad_count;
  int                                cmp_count;

  dsm_monitor i_dsm_monitor (.clk(clk), .reset_n(reset_n), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi), .miso(miso), .sampleTick(sampleTick),
    .srcRaw(srcRaw), .srcFilt(srcFilt), .dataReady(dataReady),
    .selfTestDone(selfTestDone), .selfTestFail(selfTestFail),
    .selfTestErr(selfTestErr), .flashChkDone(flashChkDone),
    .flashChkBad(flashChkBad), .overrange(overrange), .spiFault(spiFault),
    .flashUpdFail(flashUpdFail), .supplyHighPin(supplyHighPin),
    .supplyLowPin(supplyLowPin), .selfTestGo(selfTestGo),
    .flashChkGo(flashChkGo), .ioLineOut(ioLineOut), .ioLineOe(ioLineOe));

  dsm_host i_dsm_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  always #5 clk = ~clk;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic alm_exp(input logic p, input logic [13:0] v,
                                   input logic [13:0] t);
    return p ? ($signed(v) > $signed(t)) : ($signed(v) < $signed(t));
  endfunction

  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // read data comes out in the following frame
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    logic [15:0] x;
    i_dsm_host.xfer({1'b0, a, 8'h00}, x);
    i_dsm_host.xfer({1'b0, 7'h7E, 8'h00}, d);
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] v);
    logic [15:0] x;
    i_dsm_host.xfer({1'b1, a[6:1], 1'b1, v[15:8]}, x);
    i_dsm_host.xfer({1'b1, a[6:1], 1'b0, v[7:0]}, x);
  endtask

  task automatic tick;
    @(posedge clk) sampleTick <= 1'b1;
    @(posedge clk) sampleTick <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    end_sim();
  end

  initial begin
    logic [15:0] d;
    logic [15:0] c;
    logic [13:0] v;
    logic        a2;
    logic        lv;
    logic [1:0]  sv [4];
    sv = '{2'b01, 2'b01, 2'b10, 2'b00};
    {clk, reset_n, sampleTick, dataReady, selfTestDone, selfTestErr} = '0;
    {flashChkDone, flashChkBad, overrange, spiFault, flashUpdFail} = '0;
    {supplyHighPin, supplyLowPin, selfTestFail} = '0;
    srcRaw = '0;
    srcFilt = '0;
    seed = 16'h6EC0;
    bad_count = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(dsm_pkg::ADDR_MISC_CTRL, d);
    chk("misc reset", d, dsm_pkg::MISC_RST);
    rd(dsm_pkg::ADDR_STATUS, d);
    chk("status reset", d, dsm_pkg::STATUS_RST);
    rd(7'h7E, d);
    chk("unmapped", d, 16'h0000);
    @(posedge clk) dataReady <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("ready line", {ioLineOe[0], ioLineOut[0]}, 16'h0003);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(dsm_pkg::ADDR_THR1 + 7'(2 * i), seed);
      rd(dsm_pkg::ADDR_THR1 + 7'(2 * i), d);
      c = (i < 2) ? dsm_pkg::MAG_MASK : dsm_pkg::SMPL_MASK;
      chk("rw", d, seed & c);
    end
    $display("test registers done");
    @(posedge clk) {overrange, flashUpdFail} <= 2'b11;
    tick();
    @(posedge clk) {overrange, flashUpdFail} <= 2'b00;
    rd(dsm_pkg::ADDR_STATUS, d);
    chk("flags", d & 16'hFCFC, 16'h0014);
    rd(dsm_pkg::ADDR_STATUS, d);
    chk("cleared", d & 16'hFCFC, 16'h0000);
    @(posedge clk) spiFault <= 1'b1;
    tick();
    rd(dsm_pkg::ADDR_STATUS, d);
    tick();
    rd(dsm_pkg::ADDR_STATUS, d);
    chk("persist", d & 16'hFCFC, 16'h0008);
    @(posedge clk) spiFault <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) {supplyHighPin, supplyLowPin} <= sv[i];
      tick();
      tick();
      rd(dsm_pkg::ADDR_STATUS, d);
      chk("supply", {14'h0000, d[1:0]}, {14'h0000, sv[i]});
    end
    $display("test status done");
    wr(dsm_pkg::ADDR_MISC_CTRL, 16'h0406);
    chk("self go", {15'h0000, selfTestGo}, 16'h0001);
    @(posedge clk) {selfTestDone, selfTestErr, selfTestFail} <= 8'hE9;
    @(posedge clk) {selfTestDone, selfTestErr} <= 2'b00;
    tick();
    rd(dsm_pkg::ADDR_STATUS, d);
    chk("self fail", d & 16'hFC20, 16'hA420);
    chk("self stop", {15'h0000, selfTestGo}, 16'h0000);
    wr(dsm_pkg::ADDR_MISC_CTRL, 16'h0806);
    chk("flash go", {15'h0000, flashChkGo}, 16'h0001);
    @(posedge clk) {flashChkDone, flashChkBad} <= 2'b11;
    @(posedge clk) flashChkDone <= 1'b0;
    tick();
    rd(dsm_pkg::ADDR_STATUS, d);
    chk("flash sum", d & 16'h0040, 16'h0040);
    $display("test self and flash done");
    for (int k = 1; k <= dsm_pkg::NUM_SRC; k++) begin
      seed = lfsr(seed);
      a2 = seed[0];
      c = {11'h000, seed[1], 4'b0111};
      if (a2)
        c[15:12] = 4'(k);
      else
        c[11:8] = 4'(k);
      wr(dsm_pkg::ADDR_ALARM_CTRL, c);
      seed = lfsr(seed);
      wr(a2 ? dsm_pkg::ADDR_THR2 : dsm_pkg::ADDR_THR1,
         seed & dsm_pkg::MAG_MASK);
      v = 14'(lfsr(seed + 16'h1234));
      @(posedge clk) srcRaw[k-1] <= v;
      srcFilt[k-1] <= ~v;
      if (c[4] || k == 9 || k == 10)
        v = ~v;
      lv = alm_exp(seed[15], v, seed[13:0]);
      rd(dsm_pkg::ADDR_STATUS, d);
      tick();
      tick();
      rd(dsm_pkg::ADDR_STATUS, d);
      chk("alarm bit", {15'h0000, d[8 + a2]}, {15'h0000, lv});
      chk("alarm line", {14'h0000, ioLineOe[1], ioLineOut[1]},
          {14'h0000, 1'b1, lv});
    end
    $display("test static alarms done");
    wr(dsm_pkg::ADDR_ALARM_CTRL, 16'h0247);
    wr(dsm_pkg::ADDR_THR1, 16'h800A);
    wr(dsm_pkg::ADDR_CNT1, 16'h0003);
    @(posedge clk) srcRaw[1] <= 14'h0000;
    repeat (5) tick();
    @(posedge clk) srcRaw[1] <= 14'h0014;
    repeat (2) tick();
    chk("rate on", {15'h0000, ioLineOut[1]}, 16'h0001);
    repeat (4) tick();
    chk("rate off", {15'h0000, ioLineOut[1]}, 16'h0000);
    $display("test rate alarm done");
    @(posedge clk) dataReady <= 1'b0;
    wr(dsm_pkg::ADDR_ALARM_CTRL, 16'h0206);
    tick();
    chk("ready first", {ioLineOe[0], ioLineOut[0]}, 16'h0002);
    wr(dsm_pkg::ADDR_MISC_CTRL, 16'h0000);
    chk("alarm on one", {ioLineOe[0], ioLineOut[0]}, 16'h0003);
    $display("test line priority done");
    end_sim();
  end
endmodule
